// ==== shared/clk_tree_pkg.sv ====
// Constants, register map and carrier types for the converter clock tree
package clk_tree_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [7:0] OFF_DBL_OPA   = 8'h3a;
  localparam logic [7:0] OFF_DBL_OPB   = 8'h3b;
  localparam logic [7:0] OFF_DBL_OPC   = 8'h3c;
  localparam logic [7:0] OFF_LOOP_EN   = 8'h60;
  localparam logic [7:0] OFF_LOOP_BIAS = 8'h61;
  localparam logic [7:0] OFF_RX_DIV    = 8'h66;
  localparam logic [7:0] OFF_CLK_SEL   = 8'h71;
  localparam logic [7:0] OFF_LOOP_MUL  = 8'h72;
  localparam logic [7:0] OFF_AUX_DIV   = 8'h7a;
  localparam logic [7:0] OFF_LOOP_CTL  = 8'h7e;

  localparam logic [7:0] RST_VAL       = 8'h00;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int LOOP_EN_BIT    = 7;
  localparam int BIAS_PD_BIT    = 5;
  localparam int STAB_BYP_BIT   = 2;
  localparam int RX_DIV_LSB     = 0;
  localparam int RX_SEL_BIT     = 7;
  localparam int TX_SEL_BIT     = 6;
  localparam int REF_EN_BIT     = 4;
  localparam int N_LSB          = 0;
  localparam int LOCK_BIT       = 7;
  localparam int EXP_DIV_LSB    = 5;
  localparam int M_LSB          = 0;
  localparam int AUX_J_LSB      = 0;
  // Extra control register
  localparam int CTL_RESET_N    = 0;
  localparam int CTL_SDR        = 1;
  localparam int CTL_INTERP     = 2;
  localparam int CTL_DECIM      = 3;
  localparam int CTL_RX_DBL     = 4;
  localparam int CTL_TX_DBL     = 5;
  localparam int CTL_EXP_TX     = 6;
  localparam int CTL_EXP_RX     = 7;

  // ***************************************************************
  // Ratios and timing
  // ***************************************************************
  localparam int N_MAX          = 8;
  localparam int M_MAX          = 32;
  localparam int LOCK_MIN_MHZ   = 100;
  localparam int LOCK_MAX_MHZ   = 310;
  localparam int CLK_MHZ        = 25;
  localparam int LOOP_RST_MIN_NS = 25000;
  localparam int LOOP_RST_MIN_CYC =
    (LOOP_RST_MIN_NS * CLK_MHZ + 999) / 1000;

  // Converter clock tree outputs, all registered
  typedef struct packed {
    logic rx_from_loop;
    logic tx_from_loop;
    logic rx_tick;
    logic tx_tick;
    logic aux_tick;
    logic loop_tick;
    logic rx_stab_bypass;
    logic rx_doubler_en;
    logic tx_doubler_en;
    logic tx_port_clock;
    logic rx_port_clock;
    logic loop_locked;
  } clk_tree_out_s;

endpackage

// ==== logic/converter_clock_tree.sv ====
// Converter clock tree, loop multiplier model and its register file
//
// Behaviour
// (R1) Rx and tx clocks each pick input or loop
// (R2) Aux sampling clock is input divided 2J
// (R3) Aux outputs update on config port clock
// (R4) Rx divider ratios 1, 2 or 4
// (R5) Bypass bit routes rx clock around stabilizer
// (R6) Software bypasses stabilizer below 75 MHz
// (R7) Ring clock is M times reference, M 1-32
// (R8) Loop clock is ring divided by N
// (R9) Lock only within 100-310 MHz; status readable
// (R10) Loop clock usable for rx, tx, port pins
// (R11) Software enables loop, reference, clears powerdown
// (R12) Reset held 25 us, then lock acquired
// (R13) Doublers only in SDR, no interp/decim
// (R14) Software loads doubler operating points first
// (R15) Lock reads zero during and after reset
`timescale 1ns/1ps
`default_nettype none

module converter_clock_tree #(
  parameter int REF_MHZ        = clk_tree_pkg::CLK_MHZ,
  parameter int LOCK_ACQ_CYC   = 16
) (
  input  wire logic                              mclk,
  input  wire logic                              sys_rst,
  input  wire logic [clk_tree_pkg::ADDR_W-1:0]   addr,
  input  wire logic [clk_tree_pkg::DATA_W-1:0]   wdata,
  input  wire logic                              wr,
  input  wire logic                              rd,
  output logic      [clk_tree_pkg::DATA_W-1:0]   rdata,
  input  wire logic [11:0]                       aux_data,
  input  wire logic                              aux_load,
  output logic      [11:0]                       aux_dac_q,
  output clk_tree_pkg::clk_tree_out_s            clk_out
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [7:0]  dbl_opa;
    logic [7:0]  dbl_opb;
    logic [7:0]  dbl_opc;
    logic [7:0]  loop_en;
    logic [7:0]  loop_bias;
    logic [7:0]  rx_div;
    logic [7:0]  clk_sel;
    logic [6:0]  loop_mul;
    logic [7:0]  aux_div;
    logic [7:0]  loop_ctl;
    logic [7:0]  rdata;
    logic [5:0]  acc;
    logic [1:0]  rx_cnt;
    logic [1:0]  exp_cnt;
    logic [3:0]  aux_cnt;
    logic [9:0]  rst_cnt;
    logic        rst_ok;
    logic [7:0]  acq_cnt;
    logic [11:0] aux_q;
    clk_tree_pkg::clk_tree_out_s o;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  // Codes 0,1,2 give 1,2,4; the unused code falls back to 1
  function automatic logic [2:0] ratio_124(input logic [1:0] code);
    case (code)
      2'h1:    ratio_124 = 3'h2;
      2'h2:    ratio_124 = 3'h4;
      default: ratio_124 = 3'h1;
    endcase
  endfunction

  // Legal N values pass; illegal codes are treated as 1
  function automatic logic [3:0] n_ratio(input logic [3:0] code);
    if ((code >= 4'h1 && code <= 4'h6) || code == 4'h8) begin
      n_ratio = code;
    end else begin
      n_ratio = 4'h1;
    end
  endfunction

  logic [3:0] n_val;
  logic [5:0] m_val;
  logic [4:0] aux_div_val;
  logic [5:0] acc_sum;
  logic       loop_src;
  logic       rx_src;
  logic       tx_src;
  logic       loop_ready;
  logic       in_range;
  int         ring_mhz;

  always_comb begin
    // see (R7)
    m_val = {1'b0, st_ff.loop_mul[clk_tree_pkg::M_LSB +: 5]} + 6'h01;
    n_val = n_ratio(st_ff.clk_sel[clk_tree_pkg::N_LSB +: 4]); // see (R8)
    // see (R2)
    aux_div_val = {1'b0, st_ff.aux_div[clk_tree_pkg::AUX_J_LSB +: 3], 1'b0}
                  + 5'h02;
    ring_mhz = REF_MHZ * int'(m_val);
    // see (R9)
    in_range = ring_mhz >= clk_tree_pkg::LOCK_MIN_MHZ &&
               ring_mhz <= clk_tree_pkg::LOCK_MAX_MHZ;
    // see (R11)
    loop_ready = st_ff.loop_en[clk_tree_pkg::LOOP_EN_BIT] &&
                 st_ff.clk_sel[clk_tree_pkg::REF_EN_BIT] &&
                 !st_ff.loop_bias[clk_tree_pkg::BIAS_PD_BIT];
    acc_sum = st_ff.acc + m_val;
    // Loop clock runs only once locked; the tree never clocks off a
    // ring that is still searching
    loop_src = st_ff.o.loop_locked && (acc_sum >= {2'h0, n_val});
    // see (R1)
    rx_src = st_ff.clk_sel[clk_tree_pkg::RX_SEL_BIT] ? loop_src : 1'b1;
    tx_src = st_ff.clk_sel[clk_tree_pkg::TX_SEL_BIT] ? loop_src : 1'b1;
  end

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.o.rx_tick = 1'b0;
    nxt_st.o.tx_tick = 1'b0;
    nxt_st.o.aux_tick = 1'b0;
    nxt_st.o.loop_tick = 1'b0;
    nxt_st.o.tx_port_clock = 1'b0;
    nxt_st.o.rx_port_clock = 1'b0;

    if (wr) begin
      case (addr)
        clk_tree_pkg::OFF_DBL_OPA:   nxt_st.dbl_opa = wdata;
        clk_tree_pkg::OFF_DBL_OPB:   nxt_st.dbl_opb = wdata;
        clk_tree_pkg::OFF_DBL_OPC:   nxt_st.dbl_opc = wdata;
        clk_tree_pkg::OFF_LOOP_EN:   nxt_st.loop_en = wdata;
        clk_tree_pkg::OFF_LOOP_BIAS: nxt_st.loop_bias = wdata;
        clk_tree_pkg::OFF_RX_DIV:    nxt_st.rx_div = wdata;
        clk_tree_pkg::OFF_CLK_SEL:   nxt_st.clk_sel = wdata;
        // Lock bit is read-only
        clk_tree_pkg::OFF_LOOP_MUL:  nxt_st.loop_mul = wdata[6:0];
        clk_tree_pkg::OFF_AUX_DIV:   nxt_st.aux_div = wdata;
        clk_tree_pkg::OFF_LOOP_CTL:  nxt_st.loop_ctl = wdata;
        default: ;
      endcase
    end

    if (rd) begin
      case (addr)
        clk_tree_pkg::OFF_DBL_OPA:   nxt_st.rdata = st_ff.dbl_opa;
        clk_tree_pkg::OFF_DBL_OPB:   nxt_st.rdata = st_ff.dbl_opb;
        clk_tree_pkg::OFF_DBL_OPC:   nxt_st.rdata = st_ff.dbl_opc;
        clk_tree_pkg::OFF_LOOP_EN:   nxt_st.rdata = st_ff.loop_en;
        clk_tree_pkg::OFF_LOOP_BIAS: nxt_st.rdata = st_ff.loop_bias;
        clk_tree_pkg::OFF_RX_DIV:    nxt_st.rdata = st_ff.rx_div;
        clk_tree_pkg::OFF_CLK_SEL:   nxt_st.rdata = st_ff.clk_sel;
        // see (R9)
        clk_tree_pkg::OFF_LOOP_MUL:
          nxt_st.rdata = {st_ff.o.loop_locked, st_ff.loop_mul};
        clk_tree_pkg::OFF_AUX_DIV:   nxt_st.rdata = st_ff.aux_div;
        clk_tree_pkg::OFF_LOOP_CTL:  nxt_st.rdata = st_ff.loop_ctl;
        default:                     nxt_st.rdata = 8'h00;
      endcase
    end

    if (aux_load) begin // see (R3)
      nxt_st.aux_q = aux_data;
    end

    // Reset low time is measured so a short pulse cannot start acquisition
    if (!st_ff.loop_ctl[clk_tree_pkg::CTL_RESET_N]) begin
      nxt_st.acq_cnt = 8'h00;
      nxt_st.o.loop_locked = 1'b0; // see (R15)
      if (st_ff.rst_cnt < 10'(clk_tree_pkg::LOOP_RST_MIN_CYC)) begin
        nxt_st.rst_cnt = st_ff.rst_cnt + 10'h001;
        nxt_st.rst_ok = 1'b0;
      end else begin
        nxt_st.rst_ok = 1'b1; // see (R12)
      end
    end else begin
      nxt_st.rst_cnt = 10'h000;
      if (!(loop_ready && in_range)) begin
        // Losing any condition drops lock and needs a fresh reset
        nxt_st.o.loop_locked = 1'b0; // see (R9)
        nxt_st.rst_ok = 1'b0;
        nxt_st.acq_cnt = 8'h00;
      end else if (st_ff.rst_ok && !st_ff.o.loop_locked) begin
        if (st_ff.acq_cnt >= 8'(LOCK_ACQ_CYC - 1)) begin
          nxt_st.o.loop_locked = 1'b1; // see (R12)
        end else begin
          nxt_st.acq_cnt = st_ff.acq_cnt + 8'h01;
        end
      end
    end

    // Rate accumulator: loop clock averages M/N of the reference,
    // saturating at one pulse per reference cycle
    if (!st_ff.o.loop_locked) begin
      nxt_st.acc = 6'h00;
    end else if (loop_src) begin
      nxt_st.o.loop_tick = 1'b1; // see (R8)
      if (acc_sum - {2'h0, n_val} >= {2'h0, n_val}) begin
        nxt_st.acc = {2'h0, n_val} - 6'h01;
      end else begin
        nxt_st.acc = acc_sum - {2'h0, n_val};
      end
    end else begin
      nxt_st.acc = acc_sum;
    end

    if (rx_src) begin // see (R4)
      if ({1'b0, st_ff.rx_cnt} >=
          ratio_124(st_ff.rx_div[clk_tree_pkg::RX_DIV_LSB +: 2]) - 3'h1) begin
        nxt_st.rx_cnt = 2'h0;
        nxt_st.o.rx_tick = 1'b1;
      end else begin
        nxt_st.rx_cnt = st_ff.rx_cnt + 2'h1;
      end
    end
    nxt_st.o.tx_tick = tx_src;

    if ({1'b0, st_ff.aux_cnt} >= aux_div_val - 5'h01) begin // see (R2)
      nxt_st.aux_cnt = 4'h0;
      nxt_st.o.aux_tick = 1'b1;
    end else begin
      nxt_st.aux_cnt = st_ff.aux_cnt + 4'h1;
    end

    if (loop_src) begin // see (R10)
      if ({1'b0, st_ff.exp_cnt} >=
          ratio_124(st_ff.loop_mul[clk_tree_pkg::EXP_DIV_LSB +: 2]) - 3'h1)
      begin
        nxt_st.exp_cnt = 2'h0;
        nxt_st.o.tx_port_clock = st_ff.loop_ctl[clk_tree_pkg::CTL_EXP_TX];
        nxt_st.o.rx_port_clock = st_ff.loop_ctl[clk_tree_pkg::CTL_EXP_RX];
      end else begin
        nxt_st.exp_cnt = st_ff.exp_cnt + 2'h1;
      end
    end

    // see (R1)
    nxt_st.o.rx_from_loop = st_ff.clk_sel[clk_tree_pkg::RX_SEL_BIT];
    nxt_st.o.tx_from_loop = st_ff.clk_sel[clk_tree_pkg::TX_SEL_BIT];
    // see (R5)
    nxt_st.o.rx_stab_bypass = st_ff.rx_div[clk_tree_pkg::STAB_BYP_BIT];
    // see (R13)
    nxt_st.o.rx_doubler_en = st_ff.loop_ctl[clk_tree_pkg::CTL_RX_DBL] &&
      st_ff.loop_ctl[clk_tree_pkg::CTL_SDR] &&
      !st_ff.loop_ctl[clk_tree_pkg::CTL_INTERP] &&
      !st_ff.loop_ctl[clk_tree_pkg::CTL_DECIM];
    nxt_st.o.tx_doubler_en = st_ff.loop_ctl[clk_tree_pkg::CTL_TX_DBL] &&
      st_ff.loop_ctl[clk_tree_pkg::CTL_SDR] &&
      !st_ff.loop_ctl[clk_tree_pkg::CTL_INTERP] &&
      !st_ff.loop_ctl[clk_tree_pkg::CTL_DECIM];
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata     = st_ff.rdata;
  assign aux_dac_q = st_ff.aux_q;
  assign clk_out   = st_ff.o;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_rx_select;
    wr && addr == clk_tree_pkg::OFF_CLK_SEL ##1 !wr
      |=> clk_out.rx_from_loop == $past(wdata[7], 2);
  endproperty
  a_rx_select: assert property (p_rx_select) // see (R1)
    else $error("rx clock select does not follow register");
  property p_aux_gap;
    clk_out.aux_tick |=> !clk_out.aux_tick;
  endproperty
  a_aux_gap: assert property (p_aux_gap) // see (R2)
    else $error("aux clock divided by less than two");
  property p_aux_update;
    aux_load |=> aux_dac_q == $past(aux_data);
  endproperty
  a_aux_update: assert property (p_aux_update) // see (R3)
    else $error("aux output not updated on load");
  // The tick is registered, so it follows the setting one edge later
  property p_rx_div_one;
    (st_ff.rx_div[1:0] == 2'h0 && !st_ff.clk_sel[7]) [*2] |=> clk_out.rx_tick;
  endproperty
  a_rx_div_one: assert property (p_rx_div_one) // see (R4)
    else $error("rx divide by one missed a tick");
  property p_bypass;
    wr && addr == clk_tree_pkg::OFF_RX_DIV ##1 !wr
      |=> clk_out.rx_stab_bypass == $past(wdata[2], 2);
  endproperty
  a_bypass: assert property (p_bypass) // see (R5)
    else $error("stabilizer bypass does not follow register");
  property p_lock_range;
    clk_out.loop_locked |-> $past(in_range);
  endproperty
  a_lock_range: assert property (p_lock_range) // see (R9)
    else $error("lock reported outside ring range");
  property p_lock_in_reset;
    !st_ff.loop_ctl[0] |=> !clk_out.loop_locked;
  endproperty
  a_lock_in_reset: assert property (p_lock_in_reset) // see (R15)
    else $error("lock set while loop reset low");
  property p_acquire;
    $rose(clk_out.loop_locked) |-> $past(st_ff.loop_ctl[0], 8) &&
      $past(st_ff.rst_ok);
  endproperty
  a_acquire: assert property (p_acquire) // see (R12)
    else $error("lock rose without reset and acquisition");
  property p_doubler;
    clk_out.tx_doubler_en |-> $past(st_ff.loop_ctl[1] && !st_ff.loop_ctl[2]);
  endproperty
  a_doubler: assert property (p_doubler) // see (R13)
    else $error("tx doubler on outside SDR or with interpolation");
  property p_export;
    clk_out.tx_port_clock |-> $past(st_ff.o.loop_locked && st_ff.loop_ctl[6]);
  endproperty
  a_export: assert property (p_export) // see (R10)
    else $error("exported clock without lock or enable");

  c_lock: cover property ($rose(clk_out.loop_locked));
  c_rx_loop: cover property (clk_out.rx_from_loop && clk_out.rx_tick);
  c_export: cover property (clk_out.rx_port_clock);

endmodule

`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the converter clock tree
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int LACQ = 16;
  logic                        mclk;
  logic                        sys_rst;
  logic [7:0]                  addr;
  logic [7:0]                  wdata;
  logic                        wr;
  logic                        rd;
  logic [7:0]                  rdata;
  logic [11:0]                 aux_data;
  logic                        aux_load;
  logic [11:0]                 aux_dac_q;
  clk_tree_pkg::clk_tree_out_s clk_out;
  int                          failures;
  int                          tests_run;
  int                          cnt;
  int                          t;
  logic [7:0]                  rv;
  logic [7:0]                  offs [8];
  logic [7:0]                  dbl_cfg [5];
  logic [1:0]                  dbl_exp [5];

  converter_clock_tree #(.LOCK_ACQ_CYC(LACQ)) u_converter_clock_tree (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .addr      (addr),
    .wdata     (wdata),
    .wr        (wr),
    .rd        (rd),
    .rdata     (rdata),
    .aux_data  (aux_data),
    .aux_load  (aux_load),
    .aux_dac_q (aux_dac_q),
    .clk_out   (clk_out)
  );

  always #20 mclk = ~mclk;

  // ***************************************************************
  // Bus and check tasks
  // ***************************************************************
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic chk_val(input string n, input logic [11:0] e,
                         input logic [11:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk_cnt(input string n, input int e, input int g);
    tests_run++;
    if (g != e) begin
      failures++;
      $display("MISMATCH %s expected %0d seen %0d", n, e, g);
    end
  endtask

  // Derived outputs land one edge after the write edge
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic count_ticks(input int sel, input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge mclk);
      #1;
      case (sel)
        0: c += int'(clk_out.rx_tick === 1'b1);
        1: c += int'(clk_out.aux_tick === 1'b1);
        2: c += int'(clk_out.loop_tick === 1'b1);
        3: c += int'(clk_out.tx_port_clock === 1'b1);
        4: c += int'(clk_out.rx_port_clock === 1'b1);
        default: c += int'(clk_out.tx_tick === 1'b1);
      endcase
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    aux_data = 12'h000;
    aux_load = 1'b0;
    failures = 0;
    tests_run = 0;
    offs = '{clk_tree_pkg::OFF_DBL_OPA, clk_tree_pkg::OFF_DBL_OPB,
             clk_tree_pkg::OFF_DBL_OPC, clk_tree_pkg::OFF_LOOP_EN,
             clk_tree_pkg::OFF_LOOP_BIAS, clk_tree_pkg::OFF_RX_DIV,
             clk_tree_pkg::OFF_CLK_SEL, clk_tree_pkg::OFF_AUX_DIV};
    dbl_cfg = '{8'h32, 8'h12, 8'h36, 8'h3a, 8'h30};
    dbl_exp = '{2'b11, 2'b10, 2'b00, 2'b00, 2'b00};
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;

    for (int i = 0; i < 8; i++) begin
      rd_reg(offs[i], rv);
      chk_val("reset value", 12'(clk_tree_pkg::RST_VAL), 12'(rv));
      wr_reg(offs[i], 8'h5a ^ 8'(i));
      rd_reg(offs[i], rv);
      chk_val("readback", 12'(8'h5a ^ 8'(i)), 12'(rv));
      wr_reg(offs[i], 8'h00);
    end
    wr_reg(8'h10, 8'hff);
    rd_reg(8'h10, rv);
    chk_val("unmapped", 12'h000, 12'(rv));
    wr_reg(clk_tree_pkg::OFF_DBL_OPA, 8'h55);
    wr_reg(clk_tree_pkg::OFF_DBL_OPB, 8'h55);
    wr_reg(clk_tree_pkg::OFF_DBL_OPC, 8'h00);
    $display("test registers done");

    for (int c = 0; c < 3; c++) begin
      wr_reg(clk_tree_pkg::OFF_RX_DIV, 8'(c));
      settle();
      count_ticks(0, 32, cnt);
      chk_cnt("rx_tick count", 32 >> c, cnt);
    end
    count_ticks(5, 32, cnt);
    chk_cnt("tx_tick on input", 32, cnt);
    wr_reg(clk_tree_pkg::OFF_RX_DIV, 8'h04);
    settle();
    chk_bit("rx_stab_bypass", 1'b1, clk_out.rx_stab_bypass);
    wr_reg(clk_tree_pkg::OFF_RX_DIV, 8'h00);
    settle();
    chk_bit("rx_stab_bypass", 1'b0, clk_out.rx_stab_bypass);
    for (int j = 0; j < 8; j++) begin
      wr_reg(clk_tree_pkg::OFF_AUX_DIV, 8'(j));
      settle();
      count_ticks(1, 12 * (j + 1), cnt);
      chk_cnt("aux_tick count", 6, cnt);
    end
    @(posedge mclk);
    aux_data <= 12'ha5c;
    aux_load <= 1'b1;
    @(posedge mclk);
    aux_load <= 1'b0;
    #1;
    chk_val("aux_dac_q", 12'ha5c, aux_dac_q);
    for (int i = 0; i < 5; i++) begin
      wr_reg(clk_tree_pkg::OFF_LOOP_CTL, dbl_cfg[i]);
      settle();
      chk_bit("rx_doubler_en", dbl_exp[i][1],
              clk_out.rx_doubler_en);
      chk_bit("tx_doubler_en", dbl_exp[i][0],
              clk_out.tx_doubler_en);
    end
    $display("test dividers done");

    // Loop start with M = 4 (100 MHz ring) and N = 8
    wr_reg(clk_tree_pkg::OFF_LOOP_CTL, 8'h00);
    // A 25 MHz input is below 75 MHz, so the stabilizer is bypassed
    wr_reg(clk_tree_pkg::OFF_RX_DIV, 8'h04);
    wr_reg(clk_tree_pkg::OFF_LOOP_EN, 8'h80);
    wr_reg(clk_tree_pkg::OFF_LOOP_BIAS, 8'h00);
    wr_reg(clk_tree_pkg::OFF_CLK_SEL, 8'h18);
    wr_reg(clk_tree_pkg::OFF_LOOP_MUL, 8'h83);
    rd_reg(clk_tree_pkg::OFF_LOOP_MUL, rv);
    chk_val("lock status write", 12'h003, 12'(rv));
    repeat (clk_tree_pkg::LOOP_RST_MIN_CYC + 8) @(posedge mclk);
    #1;
    chk_bit("loop_locked", 1'b0, clk_out.loop_locked);
    wr_reg(clk_tree_pkg::OFF_LOOP_CTL, 8'h01);
    t = 0;
    while (clk_out.loop_locked !== 1'b1 && t < LACQ + 40) begin
      @(posedge mclk);
      #1;
      t++;
    end
    if (t >= LACQ + 40) begin
      failures++;
      $display("MISMATCH loop_locked wait expected 1 seen 0");
      stop_test();
    end
    chk_bit("lock delay", 1'b1, t >= LACQ - 1 && t <= LACQ + 4);
    rd_reg(clk_tree_pkg::OFF_LOOP_MUL, rv);
    chk_val("lock status", 12'h083, 12'(rv));
    count_ticks(2, 32, cnt);
    chk_cnt("loop_tick count", 16, cnt);
    wr_reg(clk_tree_pkg::OFF_CLK_SEL, 8'h98);
    settle();
    chk_bit("rx_from_loop", 1'b1, clk_out.rx_from_loop);
    count_ticks(0, 32, cnt);
    chk_cnt("rx_tick on loop", 16, cnt);
    wr_reg(clk_tree_pkg::OFF_CLK_SEL, 8'h58);
    settle();
    chk_bit("rx_from_loop", 1'b0, clk_out.rx_from_loop);
    chk_bit("tx_from_loop", 1'b1, clk_out.tx_from_loop);
    count_ticks(5, 32, cnt);
    chk_cnt("tx_tick on loop", 16, cnt);
    wr_reg(clk_tree_pkg::OFF_LOOP_CTL, 8'h41);
    settle();
    count_ticks(3, 32, cnt);
    chk_cnt("tx_port_clock count", 16, cnt);
    count_ticks(4, 32, cnt);
    chk_cnt("rx_port_clock count", 0, cnt);
    wr_reg(clk_tree_pkg::OFF_LOOP_CTL, 8'h81);
    settle();
    count_ticks(4, 32, cnt);
    chk_cnt("rx_port_clock count", 16, cnt);
    // Exported clock divided by two, M unchanged so lock holds
    wr_reg(clk_tree_pkg::OFF_LOOP_MUL, 8'h23);
    settle();
    count_ticks(4, 32, cnt);
    chk_cnt("rx_port_clock div2", 8, cnt);
    $display("test loop lock done");

    // M = 1 puts the ring at 25 MHz, outside the lock range
    wr_reg(clk_tree_pkg::OFF_LOOP_MUL, 8'h00);
    settle();
    chk_bit("loop_locked", 1'b0, clk_out.loop_locked);
    wr_reg(clk_tree_pkg::OFF_LOOP_MUL, 8'h03);
    wr_reg(clk_tree_pkg::OFF_LOOP_CTL, 8'h00);
    repeat (10) @(posedge mclk);
    wr_reg(clk_tree_pkg::OFF_LOOP_CTL, 8'h01);
    repeat (LACQ + 20) @(posedge mclk);
    #1;
    chk_bit("short reset lock", 1'b0, clk_out.loop_locked);
    // M = 13 puts the ring at 325 MHz, above the lock range
    wr_reg(clk_tree_pkg::OFF_LOOP_MUL, 8'h0c);
    wr_reg(clk_tree_pkg::OFF_LOOP_CTL, 8'h00);
    repeat (clk_tree_pkg::LOOP_RST_MIN_CYC + 8) @(posedge mclk);
    wr_reg(clk_tree_pkg::OFF_LOOP_CTL, 8'h01);
    repeat (LACQ + 20) @(posedge mclk);
    #1;
    chk_bit("high ring lock", 1'b0, clk_out.loop_locked);
    $display("test lock range done");
    stop_test();
  end
endmodule

`default_nettype wire
